// ---- rtl/dual_byte_latch_boundary_scan.sv ----
`timescale 1ns/1ps
module dual_byte_latch_boundary_scan (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [8:0] byte_a_data_in,
  input wire logic [8:0] byte_b_data_in,
  input wire logic byte_a_latch_enable,
  input wire logic byte_b_latch_enable,
  input wire logic byte_a_drive_enable_n,
  input wire logic byte_b_drive_enable_n,
  output logic [8:0] byte_a_data_out,
  output logic [8:0] byte_b_data_out,
  output logic byte_a_data_oe_n,
  output logic byte_b_data_oe_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // system side: pins into the pclk domain
  logic [21:0] pin_p;
  logic [8:0] a_in_p;
  logic [8:0] b_in_p;
  logic a_le_p;
  logic b_le_p;
  logic a_oe_n_p;
  logic b_oe_n_p;

  bit_sync #(.W(22)) pin_sync_p (
    .clk(pclk),
    .rst_n(presetn),
    .d({byte_a_drive_enable_n, byte_a_latch_enable, byte_b_drive_enable_n,
        byte_b_latch_enable, byte_a_data_in, byte_b_data_in}),
    .q(pin_p)
  );

  assign a_oe_n_p = pin_p[21];
  assign a_le_p = pin_p[20];
  assign b_oe_n_p = pin_p[19];
  assign b_le_p = pin_p[18];
  assign a_in_p = pin_p[17:9];
  assign b_in_p = pin_p[8:0];

  ////////////////////////////////////////////////////////////////////////////
  // latch banks and power-up arming
  logic [8:0] latch_a;
  logic [8:0] latch_b;
  logic [1:0] prev_oe_n;
  logic [1:0] armed;
  logic drive_on_a;
  logic drive_on_b;

  // storage follows data while enabled, holds after the fall
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      latch_a <= 9'h000;
      latch_b <= 9'h000;
    end
    else
    begin
      if (a_le_p) latch_a <= a_in_p;
      if (b_le_p) latch_b <= b_in_p;
    end
  end

  // a bank arms once its enable has gone high then low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_oe_n <= 2'h0;
      armed <= 2'h0;
    end
    else
    begin
      prev_oe_n <= {b_oe_n_p, a_oe_n_p};
      armed <= armed | (prev_oe_n & ~{b_oe_n_p, a_oe_n_p});
    end
  end

  // internal active-high enables
  assign drive_on_a = armed[0] & ~a_oe_n_p;
  assign drive_on_b = armed[1] & ~b_oe_n_p;

  ////////////////////////////////////////////////////////////////////////////
  // test state taken over from the tck domain
  logic xfer_tgl;
  logic xfer_s;
  logic xfer_d;
  logic [7:0] ir;
  logic [19:0] upd;
  logic [7:0] ir_x;
  logic [19:0] upd_x;
  logic test_drive;
  logic test_hiz;

  bit_sync #(.W(1)) xfer_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(xfer_tgl),
    .q(xfer_s)
  );

  // ir and upd stay still for many pclk cycles after a toggle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xfer_d <= 1'b0;
      ir_x <= scan_pkg::IR_RESET;
      upd_x <= 20'h00000;
    end
    else
    begin
      xfer_d <= xfer_s;
      if (xfer_s != xfer_d) ir_x <= ir;
      if (xfer_s != xfer_d) upd_x <= upd;
    end
  end

  // instructions that take the pins away from the system
  assign test_drive = ir_x == scan_pkg::OP_EXTEST
    || ir_x == scan_pkg::OP_EXTEST_OUT || ir_x == scan_pkg::OP_CLAMP;
  assign test_hiz = ir_x == scan_pkg::OP_HIGHZ;

  ////////////////////////////////////////////////////////////////////////////
  // output pins
  logic [8:0] next_a_out;
  logic [8:0] next_b_out;
  logic next_a_oe_n;
  logic next_b_oe_n;

  // control cells one-active enable their bank under test
  assign next_a_out = test_drive ? scan_pkg::rev9(upd_x[17:9]) : latch_a;
  assign next_b_out = test_drive ? scan_pkg::rev9(upd_x[8:0]) : latch_b;
  assign next_a_oe_n = test_hiz | (test_drive ? ~upd_x[19] : ~drive_on_a);
  assign next_b_oe_n = test_hiz | (test_drive ? ~upd_x[18] : ~drive_on_b);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      byte_a_data_out <= 9'h000;
      byte_b_data_out <= 9'h000;
      byte_a_data_oe_n <= 1'b1;
      byte_b_data_oe_n <= 1'b1;
    end
    else
    begin
      byte_a_data_out <= next_a_out;
      byte_b_data_out <= next_b_out;
      byte_a_data_oe_n <= next_a_oe_n;
      byte_b_data_oe_n <= next_b_oe_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave
  logic ctrl_tap_reset;
  logic setup;
  logic hit_ctrl;
  logic hit_stat;
  logic [31:0] rd_mux;

  assign setup = psel & ~penable;
  assign hit_ctrl = paddr == scan_pkg::ADDR_CTRL;
  assign hit_stat = paddr == scan_pkg::ADDR_STATUS;
  assign rd_mux = hit_ctrl ? {31'h00000000, ctrl_tap_reset}
    : hit_stat ? {20'h00000, test_hiz, test_drive, armed, ir_x}
    : 32'h00000000;

  // one wait-free access phase; unmapped addresses answer with error
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      ctrl_tap_reset <= scan_pkg::CTRL_RESET;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~(hit_ctrl | hit_stat);
      prdata <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
      if (psel & penable & pready & pwrite & hit_ctrl)
        ctrl_tap_reset <= pwdata[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tck domain: pins and system state for capture
  logic [21:0] pin_t;
  logic [19:0] sys_t;
  logic soft_rst_t;
  logic [41:0] cap_vec;

  bit_sync #(.W(22)) pin_sync_t (
    .clk(tck),
    .rst_n(presetn),
    .d({byte_a_drive_enable_n, byte_a_latch_enable, byte_b_drive_enable_n,
        byte_b_latch_enable, byte_a_data_in, byte_b_data_in}),
    .q(pin_t)
  );

  bit_sync #(.W(21)) sys_sync_t (
    .clk(tck),
    .rst_n(presetn),
    .d({ctrl_tap_reset, drive_on_a, drive_on_b, latch_a, latch_b}),
    .q({soft_rst_t, sys_t})
  );

  // cell order from the data-in end down to bit 0
  assign cap_vec = {pin_t[21:20], sys_t[19], pin_t[19:18], sys_t[18],
    scan_pkg::rev9(pin_t[17:9]), scan_pkg::rev9(pin_t[8:0]),
    scan_pkg::rev9(sys_t[17:9]), scan_pkg::rev9(sys_t[8:0])};

  ////////////////////////////////////////////////////////////////////////////
  // tap controller
  scan_pkg::tap_state_t st;
  scan_pkg::tap_state_t next_st;

  always_comb
  begin
    next_st = st;
    unique case (st)
      scan_pkg::TLR: next_st = tms ? scan_pkg::TLR : scan_pkg::RTI;
      scan_pkg::RTI: next_st = tms ? scan_pkg::SEL_DR : scan_pkg::RTI;
      scan_pkg::SEL_DR: next_st = tms ? scan_pkg::SEL_IR : scan_pkg::CAP_DR;
      scan_pkg::CAP_DR: next_st = tms ? scan_pkg::EX1_DR : scan_pkg::SH_DR;
      scan_pkg::SH_DR: next_st = tms ? scan_pkg::EX1_DR : scan_pkg::SH_DR;
      scan_pkg::EX1_DR: next_st = tms ? scan_pkg::UPD_DR : scan_pkg::PAU_DR;
      scan_pkg::PAU_DR: next_st = tms ? scan_pkg::EX2_DR : scan_pkg::PAU_DR;
      scan_pkg::EX2_DR: next_st = tms ? scan_pkg::UPD_DR : scan_pkg::SH_DR;
      scan_pkg::UPD_DR: next_st = tms ? scan_pkg::SEL_DR : scan_pkg::RTI;
      scan_pkg::SEL_IR: next_st = tms ? scan_pkg::TLR : scan_pkg::CAP_IR;
      scan_pkg::CAP_IR: next_st = tms ? scan_pkg::EX1_IR : scan_pkg::SH_IR;
      scan_pkg::SH_IR: next_st = tms ? scan_pkg::EX1_IR : scan_pkg::SH_IR;
      scan_pkg::EX1_IR: next_st = tms ? scan_pkg::UPD_IR : scan_pkg::PAU_IR;
      scan_pkg::PAU_IR: next_st = tms ? scan_pkg::EX2_IR : scan_pkg::PAU_IR;
      scan_pkg::EX2_IR: next_st = tms ? scan_pkg::UPD_IR : scan_pkg::SH_IR;
      scan_pkg::UPD_IR: next_st = tms ? scan_pkg::SEL_DR : scan_pkg::RTI;
    endcase
  end

  // tms sampled on the rising edge; software can hold logic reset
  always_ff @(posedge tck or negedge presetn)
  begin
    if (!presetn) st <= scan_pkg::TLR;
    else st <= soft_rst_t ? scan_pkg::TLR : next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction decode
  logic sel_full;
  logic sel_in;
  logic sel_out;
  logic sel_id;
  logic sel_byp;

  assign sel_full = ir == scan_pkg::OP_EXTEST || ir == scan_pkg::OP_SAMPLE;
  assign sel_in = ir == scan_pkg::OP_SAMPLE_IN;
  assign sel_out = ir == scan_pkg::OP_SAMPLE_OUT
    || ir == scan_pkg::OP_EXTEST_OUT;
  assign sel_id = ir == scan_pkg::OP_IDCODE;
  // clamp, highz, all-ones and unused codes
  assign sel_byp = ~(sel_full | sel_in | sel_out | sel_id);

  ////////////////////////////////////////////////////////////////////////////
  // instruction register
  logic [7:0] ir_sh;
  logic ir_change;

  assign ir_change = st == scan_pkg::UPD_IR || st == scan_pkg::UPD_DR
    || (st == scan_pkg::TLR && ir != scan_pkg::IR_RESET);

  always_ff @(posedge tck or negedge presetn)
  begin
    if (!presetn)
    begin
      ir_sh <= scan_pkg::IR_CAPTURE;
      ir <= scan_pkg::IR_RESET;
      xfer_tgl <= 1'b0;
    end
    else
    begin
      if (st == scan_pkg::CAP_IR) ir_sh <= scan_pkg::IR_CAPTURE;
      if (st == scan_pkg::SH_IR) ir_sh <= {tdi, ir_sh[7:1]};
      if (st == scan_pkg::UPD_IR) ir <= ir_sh;
      if (st == scan_pkg::TLR) ir <= scan_pkg::IR_RESET;
      if (ir_change) xfer_tgl <= ~xfer_tgl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data registers
  logic [41:0] chain;
  logic [41:0] next_chain;
  logic [21:0] in_v;
  logic [21:0] in_s;
  logic [19:0] out_v;
  logic [19:0] out_s;
  logic byp;
  logic [31:0] id_sh;
  logic dr_bit;

  // reduced chains are views onto the same cells
  assign in_v = {chain[41:40], chain[38:37], chain[35:18]};
  assign in_s = {tdi, in_v[21:1]};
  assign out_v = {chain[39], chain[36], chain[17:0]};
  assign out_s = {tdi, out_v[19:1]};
  assign next_chain = sel_in
    ? {in_s[21:20], chain[39], in_s[19:18], chain[36], in_s[17:0],
       chain[17:0]}
    : sel_out
    ? {chain[41:40], out_s[19], chain[38:37], out_s[18], chain[35:18],
       out_s[17:0]}
    : {tdi, chain[41:1]};

  // scan stage seen at tdo for the selected register
  assign dr_bit = sel_in ? chain[scan_pkg::CELL_IN_TDO]
    : (sel_full | sel_out) ? chain[0]
    : sel_id ? id_sh[0] : byp;

  always_ff @(posedge tck or negedge presetn)
  begin
    if (!presetn) chain <= 42'h00000000000;
    else if (st == scan_pkg::CAP_DR && !sel_byp && !sel_id)
      chain <= cap_vec;
    else if (st == scan_pkg::SH_DR && !sel_byp && !sel_id)
      chain <= next_chain;
  end

  // bypass and identification stages
  always_ff @(posedge tck or negedge presetn)
  begin
    if (!presetn)
    begin
      byp <= 1'b0;
      id_sh <= scan_pkg::ID_VALUE;
    end
    else
    begin
      if (st == scan_pkg::CAP_DR) byp <= 1'b0;
      if (st == scan_pkg::SH_DR) byp <= tdi;
      if (st == scan_pkg::CAP_DR) id_sh <= scan_pkg::ID_VALUE;
      if (st == scan_pkg::SH_DR) id_sh <= {tdi, id_sh[31:1]};
    end
  end

  // update stages of the control and output cells
  always_ff @(posedge tck or negedge presetn)
  begin
    if (!presetn) upd <= 20'h00000;
    else if (st == scan_pkg::UPD_DR && (sel_full | sel_out))
      upd <= out_v;
  end

  // tdo changes on the falling edge, floats outside shifting
  always_ff @(negedge tck or negedge presetn)
  begin
    if (!presetn)
    begin
      tdo <= 1'b0;
      tdo_oe_n <= 1'b1;
    end
    else
    begin
      tdo <= (st == scan_pkg::SH_IR) ? ir_sh[0] : dr_bit;
      tdo_oe_n <= ~(st == scan_pkg::SH_IR || st == scan_pkg::SH_DR);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks, pclk domain
  a_bank_transparent: assert property (
    @(posedge pclk) disable iff (!presetn)
    a_le_p ##1 !test_drive |=> byte_a_data_out == $past(a_in_p, 2))
    else $error("bank a not transparent");

  a_bank_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(a_le_p) ##1 !a_le_p |-> latch_a == $past(latch_a))
    else $error("bank a lost held value");

  a_disabled_float: assert property (
    @(posedge pclk) disable iff (!presetn)
    a_oe_n_p && !test_drive |=> byte_a_data_oe_n)
    else $error("bank a driven while disabled");

  a_powerup_float: assert property (
    @(posedge pclk) disable iff (!presetn)
    !armed[1] && !test_drive |=> byte_b_data_oe_n)
    else $error("bank b driven before arming");

  a_cell_enable: assert property (
    @(posedge pclk) disable iff (!presetn)
    test_drive && !test_hiz && upd_x[19] |=> !byte_a_data_oe_n)
    else $error("enable cell did not drive bank a");

  ////////////////////////////////////////////////////////////////////////////
  // checks, tck domain
  sequence ir_default_seq;
    st == scan_pkg::CAP_IR ##1 st == scan_pkg::EX1_IR
      ##1 st == scan_pkg::UPD_IR;
  endsequence

  a_bypass_zero: assert property (
    @(posedge tck) disable iff (!presetn)
    st == scan_pkg::CAP_DR |=> byp == 1'b0)
    else $error("bypass did not capture zero");

  a_id_capture: assert property (
    @(posedge tck) disable iff (!presetn)
    st == scan_pkg::CAP_DR |=> id_sh == scan_pkg::ID_VALUE && id_sh[0])
    else $error("identification not captured");

  a_ir_capture: assert property (
    @(posedge tck) disable iff (!presetn)
    st == scan_pkg::CAP_IR && !soft_rst_t |=> ir_sh == 8'h81)
    else $error("instruction capture pattern wrong");

  a_sample_default: assert property (
    @(posedge tck) disable iff (!presetn)
    ir_default_seq |=> ir == scan_pkg::OP_SAMPLE)
    else $error("sample not active after default update");

  a_tap_reset: assert property (
    @(posedge tck) disable iff (!presetn)
    tms [*5] |=> st == scan_pkg::TLR)
    else $error("five tms highs did not reset port");

  a_in_chain_tdo: assert property (
    @(posedge tck) disable iff (!presetn)
    st == scan_pkg::SH_DR && sel_in |=> chain[18] == $past(chain[19])
      && chain[17:0] == $past(chain[17:0]))
    else $error("input chain not cut at cell 18");

endmodule : dual_byte_latch_boundary_scan

// ---- rtl/scan_pkg.sv ----
package scan_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int unsigned BANK_W = 9;
  localparam int unsigned CHAIN_W = 42;
  localparam int unsigned IN_W = 22;
  localparam int unsigned OUT_W = 20;
  localparam int unsigned IR_W = 8;
  localparam int unsigned ID_W = 32;
  localparam int unsigned ADDR_W = 12;

  ////////////////////////////////////////////////////////////////////////////
  // instruction codes
  localparam logic [7:0] OP_EXTEST = 8'h00;
  localparam logic [7:0] OP_SAMPLE = 8'h81;
  localparam logic [7:0] OP_CLAMP = 8'h82;
  localparam logic [7:0] OP_HIGHZ = 8'h03;
  localparam logic [7:0] OP_SAMPLE_IN = 8'h83;
  localparam logic [7:0] OP_SAMPLE_OUT = 8'h84;
  localparam logic [7:0] OP_EXTEST_OUT = 8'h85;
  localparam logic [7:0] OP_IDCODE = 8'hAA;
  localparam logic [7:0] OP_BYPASS = 8'hFF;
  localparam logic [7:0] IR_CAPTURE = 8'h81;
  localparam logic [7:0] IR_RESET = OP_IDCODE;

  ////////////////////////////////////////////////////////////////////////////
  // identification fields; values are arbitrary
  localparam logic [3:0] ID_VERSION = 4'h1;
  localparam logic [5:0] ID_ENTITY = 6'h05;
  localparam logic [9:0] ID_PART = 10'h123;
  localparam logic [10:0] ID_MAKER = 11'h2A5;
  localparam logic [31:0] ID_VALUE =
    {ID_VERSION, ID_ENTITY, ID_PART, ID_MAKER, 1'b1};

  ////////////////////////////////////////////////////////////////////////////
  // boundary cell positions
  localparam int unsigned CELL_A_OE_N = 41;
  localparam int unsigned CELL_A_LE = 40;
  localparam int unsigned CELL_A_EN = 39;
  localparam int unsigned CELL_B_OE_N = 38;
  localparam int unsigned CELL_B_LE = 37;
  localparam int unsigned CELL_B_EN = 36;
  localparam int unsigned CELL_IN_TDO = 18;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic CTRL_RESET = 1'b0;
  localparam int unsigned STAT_ARMED = 8;
  localparam int unsigned STAT_DRIVE = 10;
  localparam int unsigned STAT_HIZ = 11;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } tap_state_t;

  // reverses a bank so that bit 0 sits nearest the data-in end
  function automatic logic [8:0] rev9(input logic [8:0] v);
    logic [8:0] r;
    r = 9'h000;
    for (int i = 0; i < 9; i++)
    begin
      r[i] = v[8 - i];
    end
    return r;
  endfunction : rev9

endpackage : scan_pkg

// ---- rtl/bit_sync.sv ----
`timescale 1ns/1ps
// two-stage synchroniser for levels
module bit_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : bit_sync

// ---- sim/jtag_host.sv ----
`timescale 1ns/1ps
// test controller model; tck only runs inside frames
module jtag_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // idle: clock still, pulled-up lines high
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // one 80 ns test clock cycle, tdo taken at the rising edge
  task automatic step(input logic t, input logic d, output logic q);
    tms = t;
    tdi = d;
    #20 q = tdo;
    tck = 1'b1;
    #40 tck = 1'b0;
    tdi = 1'b1;
    #20;
  endtask : step

  // five ones reach test-logic-reset, then park in run-test/idle
  task automatic tlr();
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : tlr

  // ir or dr scan from idle, n bits lsb first; n of 0 skips shifting
  task automatic scan(input logic ir, input int n,
    input logic [63:0] din, output logic [63:0] dout);
    logic q;
    dout = 64'h0;
    step(1'b1, 1'b1, q);
    if (ir)
      step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(n == 0, 1'b1, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : scan
endmodule : jtag_host

// ---- sim/test_dual_byte_latch_boundary_scan.sv ----
`timescale 1ns/1ps
// bench for the latch banks, test port and register bus
module test_dual_byte_latch_boundary_scan;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic tck, tms, tdi, tdo, tdo_oe_n, err;
  logic [8:0] a_in, b_in, a_out, b_out;
  logic a_le, b_le, a_en_n, b_en_n, a_oe_n, b_oe_n;
  logic [63:0] v, e;
  int fails, checked;
  logic [7:0] ops [10] = '{8'h81, 8'h83, 8'h84, 8'hAA, 8'hFF, 8'h5A,
    8'h82, 8'h03, 8'h00, 8'h85};
  int lens [10] = '{42, 22, 20, 32, 1, 1, 1, 1, 42, 20};

  dual_byte_latch_boundary_scan dut_u (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .byte_a_data_in(a_in), .byte_b_data_in(b_in),
    .byte_a_latch_enable(a_le), .byte_b_latch_enable(b_le),
    .byte_a_drive_enable_n(a_en_n), .byte_b_drive_enable_n(b_en_n),
    .byte_a_data_out(a_out), .byte_b_data_out(b_out),
    .byte_a_data_oe_n(a_oe_n), .byte_b_data_oe_n(b_oe_n),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));
  jtag_host host_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  // system clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [63:0] exp,
    input logic [63:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : chk

  task automatic wait_p(input int n);
    repeat (n) @(posedge pclk);
  endtask : wait_p

  // one bus transfer: setup, access until pready
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic x);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge pclk);
    end
    q = prdata;
    x = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20)
      fails++;
  endtask : apb

  task automatic test_done();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  // hang guard, nearly four times the expected run
  initial
  begin
    #300us;
    fails++;
    test_done();
  end

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    a_in = 9'h000;
    b_in = 9'h000;
    a_le = 1'b0;
    b_le = 1'b0;
    a_en_n = 1'b0;
    b_en_n = 1'b0;
    fork
      begin
        wait_p(8);
        presetn <= 1'b1;
      end
      begin
        @(posedge pclk);
        host_u.step(1'b1, 1'b1, err);
      end
    join
    host_u.tlr();
    wait_p(10);
    chk("a_oe_n", 1, a_oe_n);
    chk("b_oe_n", 1, b_oe_n);
    apb(1'b0, scan_pkg::ADDR_STATUS, 0, rd, err);
    chk("status", 10'h0AA, rd[9:0]);
    apb(1'b0, 12'h008, 0, rd, err);
    chk("pslverr", 1, err);
    $display("test power_up done");
    a_en_n <= 1'b1;
    b_en_n <= 1'b1;
    wait_p(6);
    a_en_n <= 1'b0;
    b_en_n <= 1'b0;
    a_le <= 1'b1;
    b_le <= 1'b1;
    a_in <= 9'h1A5;
    b_in <= 9'h05A;
    wait_p(8);
    chk("a_out", 9'h1A5, a_out);
    chk("b_out", 9'h05A, b_out);
    chk("a_oe_n", 0, a_oe_n);
    chk("b_oe_n", 0, b_oe_n);
    a_le <= 1'b0;
    b_le <= 1'b0;
    wait_p(6);
    a_in <= 9'h0F3;
    b_in <= 9'h10C;
    wait_p(8);
    chk("a_out held", 9'h1A5, a_out);
    chk("b_out held", 9'h05A, b_out);
    a_en_n <= 1'b1;
    a_le <= 1'b1;
    wait_p(8);
    chk("a_oe_n off", 1, a_oe_n);
    a_le <= 1'b0;
    a_en_n <= 1'b0;
    wait_p(8);
    chk("a_out new", 9'h0F3, a_out);
    $display("test latch done");
    chk("tdo_oe_n idle", 1, tdo_oe_n);
    fork
      host_u.scan(1'b0, 32, 64'h0, v);
      begin
        #480;
        chk("tdo_oe_n shift", 0, tdo_oe_n);
      end
    join
    chk("idcode", scan_pkg::ID_VALUE, v[31:0]);
    host_u.scan(1'b1, 0, 64'h0, v);
    wait_p(10);
    apb(1'b0, scan_pkg::ADDR_STATUS, 0, rd, err);
    chk("active ir", 8'h81, rd[7:0]);
    e = 64'h0;
    e[39] = 1'b1;
    e[36] = 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      e[35 - i] = a_in[i];
      e[26 - i] = b_in[i];
      e[17 - i] = a_in[i];
      e[8 - i] = 1'(9'h05A >> i);
    end
    host_u.scan(1'b0, 42, 64'h0, v);
    chk("sample chain", e, v);
    $display("test sample done");
    for (int k = 0; k < 10; k++)
    begin
      host_u.scan(1'b1, 8, {56'h0, ops[k]}, v);
      chk("ir capture", 8'h81, v[7:0]);
      host_u.scan(1'b0, 64, 64'h1, v);
      chk("chain length", 64'h1, v >> lens[k]);
    end
    $display("test chains done");
    host_u.scan(1'b1, 8, 64'h81, v);
    e = 64'h0;
    e[39] = 1'b1;
    for (int i = 0; i < 9; i++)
      e[17 - i] = 1'(9'h0C3 >> i);
    host_u.scan(1'b0, 42, e, v);
    host_u.scan(1'b1, 8, 64'h00, v);
    wait_p(10);
    chk("extest a_out", 9'h0C3, a_out);
    chk("extest a_oe_n", 0, a_oe_n);
    chk("extest b_oe_n", 1, b_oe_n);
    host_u.scan(1'b1, 8, 64'h03, v);
    wait_p(10);
    chk("highz a_oe_n", 1, a_oe_n);
    $display("test extest done");
    apb(1'b1, scan_pkg::ADDR_CTRL, 32'h1, rd, err);
    apb(1'b0, scan_pkg::ADDR_CTRL, 0, rd, err);
    chk("ctrl", 32'h1, rd);
    repeat (6) host_u.step(1'b1, 1'b1, err);
    wait_p(10);
    apb(1'b0, scan_pkg::ADDR_STATUS, 0, rd, err);
    chk("reset ir", 8'hAA, rd[7:0]);
    chk("a_out back", 9'h0F3, a_out);
    chk("a_oe_n back", 0, a_oe_n);
    apb(1'b1, scan_pkg::ADDR_CTRL, 32'h0, rd, err);
    $display("test soft_reset done");
    test_done();
  end
endmodule : test_dual_byte_latch_boundary_scan
